// >>> rcr_pkg.sv
// rcr_pkg: offsets, reset values, field positions and types of the repeater control register bank
// assumes one 100 MHz clock and an smbus host on the far side of the two-wire pins
package rcr_pkg;

    // register offsets
    localparam logic [7:0] RCR_OFS_STRAP = 8'h00;
    localparam logic [7:0] RCR_OFS_CHDIS = 8'h01;
    localparam logic [7:0] RCR_OFS_PWR = 8'h02;
    localparam logic [7:0] RCR_OFS_RSV4 = 8'h04;
    localparam logic [7:0] RCR_OFS_RSV5 = 8'h05;
    localparam logic [7:0] RCR_OFS_UPD = 8'h06;

    // values after reset
    localparam logic [7:0] RCR_RST_STRAP = 8'h00;
    localparam logic [7:0] RCR_RST_CHDIS = 8'h00;
    localparam logic [7:0] RCR_RST_PWR = 8'h00;
    localparam logic [7:0] RCR_RST_RSV4 = 8'h00;
    localparam logic [7:0] RCR_RST_RSV5 = 8'h00;
    localparam logic [7:0] RCR_RST_UPD = 8'h10;
    // synchroniser flops: scl and sda idle high, so no false edge after reset
    localparam logic [7:0] RCR_SYNC_RST = 8'h03;

    // field positions
    localparam int RCR_BIT_STRAP_RSV = 7;
    localparam int RCR_BIT_STRAP_HI = 6;
    localparam int RCR_BIT_STRAP_LO = 3;
    localparam int RCR_BIT_LOAD_DONE = 2;
    localparam int RCR_BIT_DIS_B = 1;
    localparam int RCR_BIT_DIS_A = 0;
    localparam int RCR_BIT_PD_SRC = 7;
    localparam int RCR_BIT_PD_VAL = 6;
    localparam int RCR_BIT_OVR_EN = 0;
    localparam int RCR_BIT_REG_MODE = 3;

    // smbus framing
    localparam logic [6:0] RCR_SLAVE_BASE = 7'h58;
    localparam logic [3:0] RCR_BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] RCR_LAST_TX_BIT = 4'h7;
    localparam int RCR_SYNC_WIDTH = 8;

    typedef enum logic [3:0] {
        RCR_IDLE,
        RCR_ADDR,
        RCR_ADDR_ACK,
        RCR_OFFS,
        RCR_OFFS_ACK,
        RCR_WDATA,
        RCR_WDATA_ACK,
        RCR_RDATA,
        RCR_RDATA_ACK
    } rcr_bus_state_t;

endpackage

// >>> rcr_sync.sv
// rcr_sync: two-flop synchroniser for a group of asynchronous pin levels
// assumes the levels are slow against the system clock
`timescale 1ns/100ps
module rcr_sync #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // levels
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } rcr_sync_state_t;

    rcr_sync_state_t sync_reg;
    rcr_sync_state_t sync_next;

    always_comb
    begin
        sync_next.meta = async_i;
        sync_next.stable = sync_reg.meta;
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sync_reg <= '{meta: RST_VAL, stable: RST_VAL};
        end
        else
        begin
            sync_reg <= sync_next;
        end
    end

    assign sync_o = sync_reg.stable;
endmodule // rcr_sync

// >>> rcr_cond_detect.sv
// rcr_cond_detect: start, stop and clock edge pulses from synchronised two-wire levels
// assumes both inputs already passed a synchroniser; bus idles high
`timescale 1ns/100ps
module rcr_cond_detect (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // synchronised bus levels
    input wire logic scl_i,
    input wire logic sda_i,
    // one-cycle events
    output logic start_o,
    output logic stop_o,
    output logic scl_rise_o,
    output logic scl_fall_o
);
    typedef struct packed {
        logic scl_d;
        logic sda_d;
        logic start;
        logic stop;
        logic rise;
        logic fall;
    } rcr_cond_state_t;

    rcr_cond_state_t cd_reg;
    rcr_cond_state_t cd_next;

    always_comb
    begin
        cd_next.scl_d = scl_i;
        cd_next.sda_d = sda_i;
        // sda moving while scl stays high marks a frame edge
        cd_next.start = cd_reg.scl_d & scl_i & cd_reg.sda_d & ~sda_i;
        cd_next.stop = cd_reg.scl_d & scl_i & ~cd_reg.sda_d & sda_i;
        cd_next.rise = ~cd_reg.scl_d & scl_i;
        cd_next.fall = cd_reg.scl_d & ~scl_i;
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cd_reg <= '{scl_d: 1'b1, sda_d: 1'b1, default: 1'b0};
        end
        else
        begin
            cd_reg <= cd_next;
        end
    end

    assign start_o = cd_reg.start;
    assign stop_o = cd_reg.stop;
    assign scl_rise_o = cd_reg.rise;
    assign scl_fall_o = cd_reg.fall;
endmodule // rcr_cond_detect

// >>> rcr_register_bank.sv
// rcr_register_bank: smbus slave with the low control registers of a one-lane repeater
// assumes an smbus host drives scl and open-drain sda with pull-ups outside
// What this block does
// RULE1 - the four address strap levels read back in bits 6 to 3 of offset 0x00.
// RULE2 - bit 2 of offset 0x00 reads 1 once the configuration load is done and 0 while it runs.
// RULE3 - bit 1 of offset 0x01 disables channel b and bit 0 disables channel a when set.
// RULE4 - the disable bits act only while bit 0 of offset 0x02 is 1, which software sets first.
// RULE5 - with that enable-override bit at 0 both channels stay in normal operation.
// RULE6 - bit 7 of offset 0x02 selects the register value as power-down source, else the pin.
// RULE7 - with the override active, bit 6 of offset 0x02 at 1 places the device in low power.
// RULE8 - with bit 3 of offset 0x06 at 1, register writes reach the datapath controls at once.
// RULE9 - with that bit at 0 registers stay accessible but the datapath keeps its held values.
// RULE10 - a write is start, address with write bit, offset byte, one data byte, stop, each acknowledged.
// RULE11 - a read sets the offset, repeats start with the read bit, returns one byte, then nack and stop.
// RULE12 - writes leave read-only fields alone while the other bits of the byte still update.
`timescale 1ns/100ps
module rcr_register_bank
    import rcr_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // smbus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // straps and status pins
    input wire logic [3:0] addr_strap_i,
    input wire logic cfg_load_done_i,
    input wire logic power_down_pin_i,
    // datapath controls
    output logic chan_a_disable_o,
    output logic chan_b_disable_o,
    output logic power_down_o
);
    import rcr_pkg::*;

    typedef struct packed {
        rcr_bus_state_t st;
        logic [7:0] shift;
        logic [3:0] bitcnt;
        logic rw;
        logic mack;
        logic [7:0] offset;
        logic sda_oe;
        logic strap_rsv;
        logic [7:0] chdis;
        logic [7:0] pwr;
        logic [7:0] rsv4;
        logic [7:0] rsv5;
        logic [7:0] upd;
        logic [1:0] held_dis;
        logic held_ovr_en;
        logic held_pd_src;
        logic held_pd_val;
        logic ch_a_dis;
        logic ch_b_dis;
        logic pd;
    } rcr_bank_state_t;

    rcr_bank_state_t bank_reg;
    rcr_bank_state_t bank_next;

    logic [RCR_SYNC_WIDTH-1:0] pins_sync;
    logic [3:0] strap_q;
    logic load_done_q, pd_pin_q, scl_q, sda_q;
    logic start_p, stop_p, rise_p, fall_p;
    logic [7:0] rd_byte, next_rd_byte;
    logic wr_stb, reg_mode;

    rcr_sync #(
        .WIDTH(RCR_SYNC_WIDTH),
        .RST_VAL(RCR_SYNC_RST)
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .async_i({addr_strap_i, cfg_load_done_i, power_down_pin_i, scl_i, sda_i}),
        .sync_o(pins_sync)
    );

    assign {strap_q, load_done_q, pd_pin_q, scl_q, sda_q} = pins_sync;

    rcr_cond_detect u_cond (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .scl_i(scl_q),
        .sda_i(sda_q),
        .start_o(start_p),
        .stop_o(stop_p),
        .scl_rise_o(rise_p),
        .scl_fall_o(fall_p)
    );

    function automatic logic [7:0] read_reg(input logic [7:0] ofs, input rcr_bank_state_t s,
                                            input logic [3:0] strap, input logic done);
        logic [7:0] v;
        v = 8'h00;
        case (ofs)
            RCR_OFS_STRAP:
            begin
                v[RCR_BIT_STRAP_RSV] = s.strap_rsv;
                v[RCR_BIT_STRAP_HI:RCR_BIT_STRAP_LO] = strap; // RULE1
                v[RCR_BIT_LOAD_DONE] = done; // RULE2
            end
            RCR_OFS_CHDIS: v = s.chdis;
            RCR_OFS_PWR: v = s.pwr;
            RCR_OFS_RSV4: v = s.rsv4;
            RCR_OFS_RSV5: v = s.rsv5;
            RCR_OFS_UPD: v = s.upd;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    assign rd_byte = read_reg(bank_reg.offset, bank_reg, strap_q, load_done_q);
    assign next_rd_byte = read_reg(8'(bank_reg.offset + 8'h01), bank_reg, strap_q, load_done_q);
    assign wr_stb = (bank_reg.st == RCR_WDATA) && fall_p && (bank_reg.bitcnt == RCR_BITS_PER_BYTE);
    assign reg_mode = bank_reg.upd[RCR_BIT_REG_MODE];

    always_comb
    begin
        logic [1:0] eff_dis;
        logic eff_ovr, eff_src, eff_val;
        eff_dis = 2'b00;
        eff_ovr = 1'b0;
        eff_src = 1'b0;
        eff_val = 1'b0;
        bank_next = bank_reg;

        // bus side
        if (start_p)
        begin
            bank_next.st = RCR_ADDR;
            bank_next.bitcnt = 4'h0;
            bank_next.sda_oe = 1'b0;
        end
        else if (stop_p)
        begin
            bank_next.st = RCR_IDLE;
            bank_next.sda_oe = 1'b0;
        end
        else if (rise_p)
        begin
            case (bank_reg.st)
                RCR_ADDR, RCR_OFFS, RCR_WDATA:
                begin
                    bank_next.shift = {bank_reg.shift[6:0], sda_q};
                    bank_next.bitcnt = 4'(bank_reg.bitcnt + 4'h1);
                end
                RCR_RDATA_ACK: bank_next.mack = sda_q;
                default: bank_next.mack = bank_reg.mack;
            endcase
        end
        else if (fall_p)
        begin
            case (bank_reg.st)
                RCR_ADDR:
                begin
                    if (bank_reg.bitcnt == RCR_BITS_PER_BYTE)
                    begin
                        if (bank_reg.shift[7:1] == (RCR_SLAVE_BASE | {3'h0, strap_q}))
                        begin
                            bank_next.sda_oe = 1'b1; // RULE10
                            bank_next.rw = bank_reg.shift[0];
                            bank_next.st = RCR_ADDR_ACK;
                        end
                        else
                        begin
                            bank_next.st = RCR_IDLE;
                        end
                    end
                end
                RCR_ADDR_ACK:
                begin
                    bank_next.bitcnt = 4'h0;
                    if (bank_reg.rw)
                    begin
                        bank_next.shift = rd_byte; // RULE11
                        bank_next.sda_oe = ~rd_byte[7];
                        bank_next.st = RCR_RDATA;
                    end
                    else
                    begin
                        bank_next.sda_oe = 1'b0;
                        bank_next.st = RCR_OFFS;
                    end
                end
                RCR_OFFS:
                begin
                    if (bank_reg.bitcnt == RCR_BITS_PER_BYTE)
                    begin
                        bank_next.offset = bank_reg.shift;
                        bank_next.sda_oe = 1'b1;
                        bank_next.st = RCR_OFFS_ACK;
                    end
                end
                RCR_WDATA:
                begin
                    if (bank_reg.bitcnt == RCR_BITS_PER_BYTE)
                    begin
                        bank_next.sda_oe = 1'b1; // RULE10
                        bank_next.st = RCR_WDATA_ACK;
                        case (bank_reg.offset)
                            RCR_OFS_STRAP: bank_next.strap_rsv = bank_reg.shift[RCR_BIT_STRAP_RSV]; // RULE12
                            RCR_OFS_CHDIS: bank_next.chdis = bank_reg.shift;
                            RCR_OFS_PWR: bank_next.pwr = bank_reg.shift;
                            RCR_OFS_RSV4: bank_next.rsv4 = bank_reg.shift;
                            RCR_OFS_RSV5: bank_next.rsv5 = bank_reg.shift;
                            RCR_OFS_UPD: bank_next.upd = bank_reg.shift;
                            default: bank_next.upd = bank_reg.upd;
                        endcase
                    end
                end
                RCR_OFFS_ACK, RCR_WDATA_ACK:
                begin
                    // extra bytes go to following offsets
                    if (bank_reg.st == RCR_WDATA_ACK)
                    begin
                        bank_next.offset = 8'(bank_reg.offset + 8'h01);
                    end
                    bank_next.sda_oe = 1'b0;
                    bank_next.bitcnt = 4'h0;
                    bank_next.st = RCR_WDATA;
                end
                RCR_RDATA:
                begin
                    bank_next.bitcnt = 4'(bank_reg.bitcnt + 4'h1);
                    if (bank_reg.bitcnt == RCR_LAST_TX_BIT)
                    begin
                        bank_next.sda_oe = 1'b0;
                        bank_next.st = RCR_RDATA_ACK;
                    end
                    else
                    begin
                        bank_next.shift = {bank_reg.shift[6:0], 1'b0};
                        bank_next.sda_oe = ~bank_reg.shift[6];
                    end
                end
                RCR_RDATA_ACK:
                begin
                    // nack ends the read, ack streams the next offset
                    if (bank_reg.mack)
                    begin
                        bank_next.st = RCR_IDLE; // RULE11
                    end
                    else
                    begin
                        bank_next.offset = 8'(bank_reg.offset + 8'h01);
                        bank_next.shift = next_rd_byte;
                        bank_next.sda_oe = ~next_rd_byte[7];
                        bank_next.bitcnt = 4'h0;
                        bank_next.st = RCR_RDATA;
                    end
                end
                default: bank_next.st = RCR_IDLE;
            endcase
        end

        // datapath side: live registers, or values held while register mode is off
        eff_dis = reg_mode ? bank_reg.chdis[RCR_BIT_DIS_B:RCR_BIT_DIS_A] : bank_reg.held_dis; // RULE8 RULE9
        eff_ovr = reg_mode ? bank_reg.pwr[RCR_BIT_OVR_EN] : bank_reg.held_ovr_en; // RULE8 RULE9
        eff_src = reg_mode ? bank_reg.pwr[RCR_BIT_PD_SRC] : bank_reg.held_pd_src; // RULE8 RULE9
        eff_val = reg_mode ? bank_reg.pwr[RCR_BIT_PD_VAL] : bank_reg.held_pd_val; // RULE8 RULE9
        bank_next.held_dis = eff_dis;
        bank_next.held_ovr_en = eff_ovr;
        bank_next.held_pd_src = eff_src;
        bank_next.held_pd_val = eff_val;
        bank_next.ch_a_dis = eff_ovr & eff_dis[0]; // RULE3 RULE4 RULE5
        bank_next.ch_b_dis = eff_ovr & eff_dis[1]; // RULE3 RULE4 RULE5
        bank_next.pd = eff_src ? eff_val : pd_pin_q; // RULE6 RULE7
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            bank_reg <= '{st: RCR_IDLE, strap_rsv: RCR_RST_STRAP[RCR_BIT_STRAP_RSV], chdis: RCR_RST_CHDIS,
                          pwr: RCR_RST_PWR, rsv4: RCR_RST_RSV4, rsv5: RCR_RST_RSV5, upd: RCR_RST_UPD,
                          default: '0};
        end
        else
        begin
            bank_reg <= bank_next;
        end
    end

    // open drain: only the enable moves
    assign sda_o = 1'b0;
    assign sda_oe_o = bank_reg.sda_oe;
    assign chan_a_disable_o = bank_reg.ch_a_dis;
    assign chan_b_disable_o = bank_reg.ch_b_dis;
    assign power_down_o = bank_reg.pd;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_live_chdis_write;
        wr_stb && reg_mode && (bank_reg.offset == RCR_OFS_CHDIS) && bank_reg.pwr[RCR_BIT_OVR_EN];
    endsequence

    sequence s_strap_load;
        (bank_reg.st == RCR_ADDR_ACK) && fall_p && bank_reg.rw && (bank_reg.offset == RCR_OFS_STRAP);
    endsequence

    sequence s_addr_match;
        (bank_reg.st == RCR_ADDR) && fall_p && (bank_reg.bitcnt == RCR_BITS_PER_BYTE)
            && (bank_reg.shift[7:1] == (RCR_SLAVE_BASE | {3'h0, strap_q}));
    endsequence

    AST_STRAP_FIELD: assert property (s_strap_load |=> (bank_reg.shift[6:3] == $past(strap_q))) // RULE1
        else $error("strap field does not show strap levels");
    AST_LOAD_DONE: assert property (s_strap_load |=> (bank_reg.shift[2] == $past(load_done_q))) // RULE2
        else $error("load done bit wrong");
    AST_CH_DISABLE: assert property (s_live_chdis_write |-> ##2 ({chan_b_disable_o, chan_a_disable_o} // RULE3
        == $past(bank_reg.shift[1:0], 2)))
        else $error("channel disable write not applied");
    AST_OVR_OFF: assert property ((reg_mode && !bank_reg.pwr[RCR_BIT_OVR_EN]) |=> !chan_a_disable_o // RULE5
        && !chan_b_disable_o)
        else $error("channel disabled without enable override");
    AST_OVR_ON: assert property ((reg_mode && bank_reg.pwr[RCR_BIT_OVR_EN]) |=> ({chan_b_disable_o, // RULE4
        chan_a_disable_o} == $past(bank_reg.chdis[1:0])))
        else $error("enable override did not pass disable bits");
    AST_PD_REG: assert property ((reg_mode && bank_reg.pwr[RCR_BIT_PD_SRC]) |=> (power_down_o // RULE7
        == $past(bank_reg.pwr[RCR_BIT_PD_VAL])))
        else $error("power down override value not applied");
    AST_PD_PIN: assert property ((reg_mode && !bank_reg.pwr[RCR_BIT_PD_SRC]) |=> (power_down_o // RULE6
        == $past(pd_pin_q)))
        else $error("power down does not follow pin");
    AST_HOLD: assert property ((!reg_mode && !$past(reg_mode)) |=> $stable(chan_a_disable_o) // RULE9
        && $stable(chan_b_disable_o))
        else $error("datapath changed while register mode off");
    AST_ADDR_ACK: assert property (s_addr_match |=> sda_oe_o && (bank_reg.st == RCR_ADDR_ACK)) // RULE10
        else $error("address not acknowledged");
    AST_WR_ACK: assert property ((wr_stb && !start_p && !stop_p) |=> sda_oe_o) // RULE10
        else $error("data byte not acknowledged");
    AST_RO_KEEP: assert property ((wr_stb && !start_p && !stop_p && (bank_reg.offset == RCR_OFS_STRAP)) // RULE12
        |=> (bank_reg.strap_rsv == $past(bank_reg.shift[7])) && (rd_byte[1:0] == 2'b00))
        else $error("write to offset zero mishandled");
endmodule // rcr_register_bank

// >>> rcr_host_model.sv
// rcr_host_model: behavioural smbus host for the repeater register bank
// assumes a pull-up on sda outside; pins change on falling clock edges only
`timescale 1ns/100ps
module rcr_host_model (
    // clock
    input wire logic sys_clk_i,
    // smbus pins
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_oe_o
);
    initial
    begin
        scl_o = 1'b1;
        sda_oe_o = 1'b0;
    end

    // third of a bit, well above the five-clock minimum
    task automatic hw();
        repeat (8) @(negedge sys_clk_i);
    endtask

    // start or repeated start
    task automatic cond_start();
        sda_oe_o = 1'b0;
        hw();
        scl_o = 1'b1;
        hw();
        sda_oe_o = 1'b1;
        hw();
        scl_o = 1'b0;
        hw();
    endtask

    task automatic cond_stop();
        sda_oe_o = 1'b1;
        hw();
        scl_o = 1'b1;
        hw();
        sda_oe_o = 1'b0;
        hw();
    endtask

    // data held over the whole high phase; line sampled just before the fall
    task automatic bit_io(input logic tx, output logic rx);
        sda_oe_o = ~tx;
        hw();
        scl_o = 1'b1;
        hw();
        rx = sda_i;
        scl_o = 1'b0;
        hw();
    endtask

    // msb first, ninth bit released by the host
    task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_io(tx[i], rx[i]);
        bit_io(1'b1, ack);
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] ofs, input logic [7:0] d, output logic [2:0] acks);
        logic [7:0] rx;
        cond_start();
        byte_io({a, 1'b0}, rx, acks[2]);
        byte_io(ofs, rx, acks[1]);
        byte_io(d, rx, acks[0]);
        cond_stop();
    endtask

    // released ninth bit after the data byte is the closing nack
    task automatic rd(input logic [6:0] a, input logic [7:0] ofs, output logic [7:0] d, output logic [2:0] acks);
        logic [7:0] rx;
        logic nk;
        cond_start();
        byte_io({a, 1'b0}, rx, acks[2]);
        byte_io(ofs, rx, acks[1]);
        cond_start();
        byte_io({a, 1'b1}, rx, acks[0]);
        byte_io(8'hff, d, nk);
        cond_stop();
    endtask
endmodule // rcr_host_model

// >>> testbench.sv
// testbench: register bank driven through the behavioural smbus host
// assumes a 100 MHz clock; bench inputs change on falling edges only
`timescale 1ns/100ps
module testbench;
    import rcr_pkg::*;
    typedef struct packed {
        logic [7:0] ofs;
        logic [7:0] wd;
        logic [7:0] rd;
    } rcr_row_t;
    logic sys_clk_i, rst_i, scl, sda, dev_sda, dev_oe, host_oe, done, pd_pin, dis_a, dis_b, pd;
    logic [3:0] strap;
    logic [6:0] adr;
    logic [2:0] acks;
    int fails = 0;
    int n_compared = 0;
    int cycles = 0;
    rcr_row_t rows [5];

    // open-drain data line with pull-up
    assign sda = ~(host_oe | dev_oe);

    rcr_register_bank i_rcr_register_bank (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda),
        .sda_o(dev_sda), .sda_oe_o(dev_oe), .addr_strap_i(strap), .cfg_load_done_i(done),
        .power_down_pin_i(pd_pin), .chan_a_disable_o(dis_a), .chan_b_disable_o(dis_b), .power_down_o(pd));
    rcr_host_model i_rcr_host_model (.sys_clk_i(sys_clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe));

    initial
    begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        if (fails == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic put(input logic [7:0] o, input logic [7:0] d);
        i_rcr_host_model.wr(adr, o, d, acks);
        chk({5'h00, acks}, 8'h00);
    endtask

    task automatic get(input logic [7:0] o, input logic [7:0] e);
        logic [7:0] d;
        i_rcr_host_model.rd(adr, o, d, acks);
        chk({5'h00, acks}, 8'h00);
        chk(d, e);
    endtask

    // expected {chan b, chan a, power down}
    task automatic outs(input logic [2:0] e);
        chk({5'h00, dis_b, dis_a, pd}, {5'h00, e});
    endtask

    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            fails++;
            end_sim();
        end
    end

    initial
    begin
        rst_i = 1'b1;
        strap = 4'h5;
        done = 1'b0;
        pd_pin = 1'b0;
        adr = RCR_SLAVE_BASE | 7'h05;
        rows = '{'{RCR_OFS_CHDIS, 8'h03, 8'h03}, '{RCR_OFS_PWR, 8'h01, 8'h01}, '{RCR_OFS_STRAP, 8'hff, 8'hac},
            '{RCR_OFS_RSV4, 8'h5a, 8'h5a}, '{8'h03, 8'h77, 8'h00}};
        repeat (6) @(negedge sys_clk_i);
        outs(3'b000);
        rst_i = 1'b0;
        repeat (4) @(negedge sys_clk_i);
        get(RCR_OFS_UPD, RCR_RST_UPD);
        get(RCR_OFS_CHDIS, RCR_RST_CHDIS);
        get(RCR_OFS_PWR, RCR_RST_PWR);
        get(RCR_OFS_RSV5, RCR_RST_RSV5);
        get(RCR_OFS_STRAP, 8'h28);
        done = 1'b1;
        foreach (rows[i])
        begin
            put(rows[i].ofs, rows[i].wd);
            get(rows[i].ofs, rows[i].rd);
        end
        outs(3'b000);
        put(RCR_OFS_UPD, 8'h18);
        outs(3'b110);
        put(RCR_OFS_PWR, 8'h00);
        outs(3'b000);
        put(RCR_OFS_PWR, 8'hc1);
        outs(3'b111);
        pd_pin = 1'b1;
        put(RCR_OFS_PWR, 8'h81);
        outs(3'b110);
        put(RCR_OFS_PWR, 8'h01);
        outs(3'b111);
        pd_pin = 1'b0;
        repeat (8) @(negedge sys_clk_i);
        outs(3'b110);
        put(RCR_OFS_UPD, 8'h10);
        put(RCR_OFS_CHDIS, 8'h01);
        outs(3'b110);
        get(RCR_OFS_CHDIS, 8'h01);
        put(RCR_OFS_UPD, 8'h18);
        outs(3'b010);
        // live write of the disable field while register mode is on
        put(RCR_OFS_CHDIS, 8'h02);
        outs(3'b100);
        // foreign address must be ignored
        i_rcr_host_model.wr(adr ^ 7'h01, RCR_OFS_CHDIS, 8'h00, acks);
        chk({5'h00, acks}, 8'h07);
        outs(3'b100);
        rst_i = 1'b1;
        @(negedge sys_clk_i);
        outs(3'b000);
        rst_i = 1'b0;
        repeat (4) @(negedge sys_clk_i);
        get(RCR_OFS_CHDIS, RCR_RST_CHDIS);
        end_sim();
    end
endmodule // testbench
